// >>> rtl/iso_irq_link_regs.sv
`timescale 1ns/1ps
`default_nettype none
module iso_irq_link_regs #(
   parameter int CTX_COUNT = 8
) (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic soft_reset_i,
   // Avalon-MM slave.
   input wire iso_irq_link_pkg::bus_req_type bus_req_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // Event sources.
   input wire iso_irq_link_pkg::ctx_irq_type ctx_irq_i,
   input wire logic [9:0] main_event_low_i,
   input wire logic cycle_overrun_event_i,
   input wire logic [7:0] rx_ctx_sync_filter_i,
   // Results.
   output logic main_irq_o,
   output logic [7:0] rx_ctx_sync_filter_o,
   output logic [7:0] fairness_limit_o,
   output iso_irq_link_pkg::link_flags_type link_flags_o
);
   import iso_irq_link_pkg::*;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [9:0] main_enable_mask; // Low ten bits of the main mask.
   logic [CTX_COUNT-1:0] per_tx_context_events; // Latched tx events.
   logic [CTX_COUNT-1:0] per_tx_context_enables; // Tx enables.
   logic [CTX_COUNT-1:0] per_rx_context_events; // Latched rx events.
   logic [CTX_COUNT-1:0] per_rx_context_enables; // Rx enables.
   logic [CTX_COUNT-1:0] tx_irq_last; // Previous tx pulse level.
   logic [CTX_COUNT-1:0] rx_irq_last; // Previous rx pulse level.
   logic [7:0] fairness_priority_limit; // Priority request limit.
   logic [31:0] link_flags; // Link control word.
   logic ack_pending; // One wait cycle has passed.
   logic [31:0] next_readdata; // Decoded read value.
   logic [9:0] main_event_register; // Main events with summaries.
   logic tx_context_summary_event; // Unlatched tx summary.
   logic rx_context_summary_event; // Unlatched rx summary.
   logic [31:0] wmask; // Byte-enable expanded write mask.
   logic do_write; // Write accepted this edge.
   logic do_read; // Read accepted this edge.

   // Widens a context vector to a bus word with zero upper bits.
   function automatic logic [31:0] widen(input logic [CTX_COUNT-1:0] v);
      logic [31:0] w;
      w = ZERO_WORD;
      w[CTX_COUNT-1:0] = v;
      return w;
   endfunction

   // -------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------
   // Every access waits one cycle, then completes; the read mux is
   // registered on the edge that takes the request so readdata comes from flops.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_pending <= 1'b0;
      end else if (clk_en_i) begin
         if (ack_pending) begin
            ack_pending <= 1'b0;
         end else if (bus_req_i.read || bus_req_i.write) begin
            ack_pending <= 1'b1;
         end
      end
   end

   // Waitrequest drops only in the cycle that completes an access.
   assign waitrequest_o = !(ack_pending && clk_en_i);
   assign do_write = ack_pending && clk_en_i && bus_req_i.write;
   assign do_read = ack_pending && clk_en_i && bus_req_i.read;

   // Byte enables turn into a bit mask for write-one strobes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{bus_req_i.byteenable[i]}};
      end
   end

   // -------------------------------------------------------------------
   // Summaries and interrupt
   // -------------------------------------------------------------------
   // The summaries are not latched: they follow the masked event vectors.
   assign tx_context_summary_event =
      |(per_tx_context_events & per_tx_context_enables);
   assign rx_context_summary_event =
      |(per_rx_context_events & per_rx_context_enables);

   // Summary bits replace whatever the main event inputs show there.
   always_comb begin
      main_event_register = main_event_low_i;
      main_event_register[BIT_TX_SUMMARY] = tx_context_summary_event;
      main_event_register[BIT_RX_SUMMARY] = rx_context_summary_event;
   end

   // Only enabled, pending events raise the processor line.
   assign main_irq_o =
      |(main_event_register & main_enable_mask);

   // -------------------------------------------------------------------
   // Main mask
   // -------------------------------------------------------------------
   // Set and clear aliases act bitwise; bits 31:10 are never stored.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_enable_mask <= '0;
      end else if (clk_en_i && do_write) begin
         if (bus_req_i.address == OFF_MAIN_MASK_SET) begin
            main_enable_mask <= main_enable_mask |
               (bus_req_i.writedata[9:0] & wmask[9:0]);
         end else if (bus_req_i.address == OFF_MAIN_MASK_CLEAR) begin
            main_enable_mask <= main_enable_mask &
               ~(bus_req_i.writedata[9:0] & wmask[9:0]);
         end
      end
   end

   // -------------------------------------------------------------------
   // Per-context events
   // -------------------------------------------------------------------
   // Remember last pulse levels so that a pulse sets a bit only on its rising edge.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_irq_last <= '0;
         rx_irq_last <= '0;
      end else if (clk_en_i) begin
         tx_irq_last <= ctx_irq_i.tx[CTX_COUNT-1:0];
         rx_irq_last <= ctx_irq_i.rx[CTX_COUNT-1:0];
      end
   end

   // Events set on an edge or a set write; only a clear write clears.
   // An edge landing on a clear write wins, so no event is lost.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         per_tx_context_events <= '0;
         per_rx_context_events <= '0;
      end else if (clk_en_i) begin
         per_tx_context_events <= (per_tx_context_events &
            ~((do_write && bus_req_i.address == OFF_TX_EVENT_CLEAR) ?
              bus_req_i.writedata[CTX_COUNT-1:0] & wmask[CTX_COUNT-1:0] :
              '0)) |
            (ctx_irq_i.tx[CTX_COUNT-1:0] & ~tx_irq_last) |
            ((do_write && bus_req_i.address == OFF_TX_EVENT_SET) ?
              bus_req_i.writedata[CTX_COUNT-1:0] & wmask[CTX_COUNT-1:0] :
              '0);
         per_rx_context_events <= (per_rx_context_events &
            ~((do_write && bus_req_i.address == OFF_RX_EVENT_CLEAR) ?
              bus_req_i.writedata[CTX_COUNT-1:0] & wmask[CTX_COUNT-1:0] :
              '0)) |
            (ctx_irq_i.rx[CTX_COUNT-1:0] & ~rx_irq_last) |
            ((do_write && bus_req_i.address == OFF_RX_EVENT_SET) ?
              bus_req_i.writedata[CTX_COUNT-1:0] & wmask[CTX_COUNT-1:0] :
              '0);
      end
   end

   // -------------------------------------------------------------------
   // Per-context masks
   // -------------------------------------------------------------------
   // Enables come up cleared, so no context interrupts before setup.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         per_tx_context_enables <= '0;
         per_rx_context_enables <= '0;
      end else if (clk_en_i && do_write) begin
         unique case (bus_req_i.address)
            OFF_TX_MASK_SET: begin
               per_tx_context_enables <= per_tx_context_enables |
                  (bus_req_i.writedata[CTX_COUNT-1:0] &
                   wmask[CTX_COUNT-1:0]);
            end
            OFF_TX_MASK_CLEAR: begin
               per_tx_context_enables <= per_tx_context_enables &
                  ~(bus_req_i.writedata[CTX_COUNT-1:0] &
                    wmask[CTX_COUNT-1:0]);
            end
            OFF_RX_MASK_SET: begin
               per_rx_context_enables <= per_rx_context_enables |
                  (bus_req_i.writedata[CTX_COUNT-1:0] &
                   wmask[CTX_COUNT-1:0]);
            end
            OFF_RX_MASK_CLEAR: begin
               per_rx_context_enables <= per_rx_context_enables &
                  ~(bus_req_i.writedata[CTX_COUNT-1:0] &
                    wmask[CTX_COUNT-1:0]);
            end
            default: begin
               // Other offsets leave the enables alone.
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Fairness limit
   // -------------------------------------------------------------------
   // Plain read-write byte; soft reset returns it to zero.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fairness_priority_limit <= '0;
      end else if (clk_en_i) begin
         if (soft_reset_i) begin
            fairness_priority_limit <= '0;
         end else if (do_write && bus_req_i.address == OFF_FAIRNESS &&
                      bus_req_i.byteenable[0]) begin
            fairness_priority_limit <=
               bus_req_i.writedata[FAIRNESS_BITS-1:0];
         end
      end
   end

   assign fairness_limit_o = fairness_priority_limit;

   // -------------------------------------------------------------------
   // Link flags
   // -------------------------------------------------------------------
   // Soft reset clears every flag except the sync filter lock, which
   // only the hardware reset or a link write changes. Cycle source never stores a one,
   // so a careless write cannot select the missing external timer.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_flags <= ZERO_WORD;
      end else if (clk_en_i) begin
         if (soft_reset_i) begin
            link_flags <= link_flags &
               (ZERO_WORD | (32'h0000_0001 << BIT_SYNC_LOCK));
         end else begin
            if (do_write && bus_req_i.address == OFF_LINK_SET) begin
               link_flags <= link_flags | (bus_req_i.writedata &
                  wmask & LINK_WRITABLE);
            end else if (do_write && bus_req_i.address == OFF_LINK_CLEAR) begin
               link_flags <= link_flags &
                  ~(bus_req_i.writedata & wmask & LINK_WRITABLE);
            end
            // Overrun drops mastership and keeps it down while pending.
            if (cycle_overrun_event_i) begin
               link_flags[BIT_CYCLE_MASTER] <= 1'b0;
            end
         end
      end
   end

   // Flags go out to the cycle timer, cycle-start logic and receiver.
   // One assignment for the whole carrier keeps the output single-driven.
   assign link_flags_o = '{
      cycle_master_flag: link_flags[BIT_CYCLE_MASTER],
      cycle_timer_run: link_flags[BIT_CYCLE_TIMER_RUN],
      accept_phy_packets: link_flags[BIT_ACCEPT_PHY],
      accept_self_id_packets: link_flags[BIT_ACCEPT_SELF_ID],
      sync_filter_force_lock: link_flags[BIT_SYNC_LOCK]
   };

   // The lock forces each receive context's sync filter bit to one.
   assign rx_ctx_sync_filter_o = link_flags[BIT_SYNC_LOCK] ?
      8'hff : rx_ctx_sync_filter_i;

   // -------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------
   always_comb begin
      next_readdata = UNMAPPED_READ;
      unique case (bus_req_i.address)
         OFF_MAIN_MASK_SET, OFF_MAIN_MASK_CLEAR: begin
            next_readdata[MAIN_LOW_BITS-1:0] = main_enable_mask;
         end
         OFF_MAIN_EVENT: begin
            next_readdata[MAIN_LOW_BITS-1:0] = main_event_register;
         end
         OFF_TX_EVENT_SET: begin
            next_readdata = widen(per_tx_context_events);
         end
         OFF_TX_EVENT_CLEAR: begin
            next_readdata = widen(per_tx_context_events &
                                  per_tx_context_enables);
         end
         OFF_TX_MASK_SET, OFF_TX_MASK_CLEAR: begin
            next_readdata = widen(per_tx_context_enables);
         end
         OFF_RX_EVENT_SET: begin
            next_readdata = widen(per_rx_context_events);
         end
         OFF_RX_EVENT_CLEAR: begin
            next_readdata = widen(per_rx_context_events &
                                  per_rx_context_enables);
         end
         OFF_RX_MASK_SET, OFF_RX_MASK_CLEAR: begin
            next_readdata = widen(per_rx_context_enables);
         end
         OFF_FAIRNESS: begin
            next_readdata[FAIRNESS_BITS-1:0] =
               fairness_priority_limit;
         end
         OFF_LINK_SET, OFF_LINK_CLEAR: begin
            next_readdata = link_flags;
         end
         default: begin
            next_readdata = UNMAPPED_READ;
         end
      endcase
   end

   // Read data is captured on the edge that takes the request and held after it.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         readdata_o <= ZERO_WORD;
      end else if (clk_en_i && !ack_pending && bus_req_i.read) begin
         readdata_o <= next_readdata;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/iso_irq_link_pkg.sv
package iso_irq_link_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_MAIN_MASK_SET = 8'h88;
   localparam logic [7:0] OFF_MAIN_MASK_CLEAR = 8'h8c;
   localparam logic [7:0] OFF_MAIN_EVENT = 8'h80;
   localparam logic [7:0] OFF_TX_EVENT_SET = 8'h90;
   localparam logic [7:0] OFF_TX_EVENT_CLEAR = 8'h94;
   localparam logic [7:0] OFF_TX_MASK_SET = 8'h98;
   localparam logic [7:0] OFF_TX_MASK_CLEAR = 8'h9c;
   localparam logic [7:0] OFF_RX_EVENT_SET = 8'ha0;
   localparam logic [7:0] OFF_RX_EVENT_CLEAR = 8'ha4;
   localparam logic [7:0] OFF_RX_MASK_SET = 8'ha8;
   localparam logic [7:0] OFF_RX_MASK_CLEAR = 8'hac;
   localparam logic [7:0] OFF_FAIRNESS = 8'hdc;
   localparam logic [7:0] OFF_LINK_SET = 8'he0;
   localparam logic [7:0] OFF_LINK_CLEAR = 8'he4;

   // -------------------------------------------------------------------
   // Field layout
   // -------------------------------------------------------------------
   localparam int MAIN_LOW_BITS = 10;
   localparam int BIT_TX_SUMMARY = 6;
   localparam int BIT_RX_SUMMARY = 7;
   localparam int BIT_CYCLE_SOURCE = 22;
   localparam int BIT_CYCLE_MASTER = 21;
   localparam int BIT_CYCLE_TIMER_RUN = 20;
   localparam int BIT_ACCEPT_PHY = 10;
   localparam int BIT_ACCEPT_SELF_ID = 9;
   localparam int BIT_SYNC_LOCK = 6;
   localparam int FAIRNESS_BITS = 8;

   // Writable link flags; cycle source is held at zero.
   localparam logic [31:0] LINK_WRITABLE = 32'h0030_0640;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // -------------------------------------------------------------------
   // Bus request carrier
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bus_req_type;

   // Per-context completion pulses from the DMA engines.
   typedef struct packed {
      logic [7:0] tx;
      logic [7:0] rx;
   } ctx_irq_type;

   // Link flags driven to the link core.
   typedef struct packed {
      logic cycle_master_flag;
      logic cycle_timer_run;
      logic accept_phy_packets;
      logic accept_self_id_packets;
      logic sync_filter_force_lock;
   } link_flags_type;

endpackage

// >>> sim/iso_irq_link_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------
// Port-level checker for the interrupt and link register bank
// -----------------------------------------------------------------------
module iso_irq_link_regs_sva #(
   parameter int CTX_COUNT = 8
) (
   // Clock and controls.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic soft_reset_i,
   // Bus side.
   input wire iso_irq_link_pkg::bus_req_type bus_req_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   // Events and results.
   input wire iso_irq_link_pkg::ctx_irq_type ctx_irq_i,
   input wire logic [9:0] main_event_low_i,
   input wire logic cycle_overrun_event_i,
   input wire logic [7:0] rx_ctx_sync_filter_i,
   input wire logic main_irq_o,
   input wire logic [7:0] rx_ctx_sync_filter_o,
   input wire logic [7:0] fairness_limit_o,
   input wire iso_irq_link_pkg::link_flags_type link_flags_o
);
   import iso_irq_link_pkg::*;

   // One clock domain, so clocking and reset are declared once.
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // A request is pending when either strobe is up.
   wire logic busy_req = bus_req_i.read | bus_req_i.write;

   // The first edge that sees a request, and the completing edge.
   sequence s_taken;
      busy_req && waitrequest_o && clk_en_i;
   endsequence
   sequence s_done;
      busy_req && !waitrequest_o;
   endsequence

   a_ack_next_cycle: assert property (
      s_taken ##1 clk_en_i |-> !waitrequest_o)
      else $error("waitrequest did not drop one cycle after a request");
   a_ack_one_cycle: assert property (
      !waitrequest_o |=> waitrequest_o)
      else $error("waitrequest stayed low for more than one cycle");
   a_ack_needs_req: assert property (
      !waitrequest_o |-> busy_req)
      else $error("waitrequest dropped with no request pending");
   a_fair_write_lands: assert property (
      s_done ##0 (bus_req_i.write && bus_req_i.address == OFF_FAIRNESS
      && bus_req_i.byteenable[0] && !soft_reset_i)
      |=> fairness_limit_o == $past(bus_req_i.writedata[7:0]))
      else $error("priority limit did not take the written byte");
   a_link_set_lands: assert property (
      s_done ##0 (bus_req_i.write && bus_req_i.address == OFF_LINK_SET
      && bus_req_i.writedata[20] && bus_req_i.byteenable[2]
      && !soft_reset_i) |=> link_flags_o.cycle_timer_run)
      else $error("set alias write did not raise the timer run flag");
   a_overrun_clears: assert property (
      cycle_overrun_event_i && clk_en_i |=> !link_flags_o.cycle_master_flag)
      else $error("cycle master flag survived a cycle overrun");
   a_soft_clears: assert property (
      soft_reset_i && clk_en_i && !busy_req |=> fairness_limit_o == 8'h00
      && {link_flags_o[4:1]} == 4'h0 && $stable(link_flags_o[0]))
      else $error("soft reset did not clear flags or touched the lock");
   a_freeze_holds: assert property (
      !clk_en_i |=> $stable(link_flags_o) && $stable(fairness_limit_o))
      else $error("state moved while the clock enable was low");
   a_lock_forces: assert property (
      link_flags_o.sync_filter_force_lock |-> rx_ctx_sync_filter_o == 8'hff)
      else $error("locked sync filter bits are not all ones");
   a_filter_passes: assert property (
      !link_flags_o.sync_filter_force_lock
      |-> rx_ctx_sync_filter_o == rx_ctx_sync_filter_i)
      else $error("unlocked sync filter bits differ from software value");
endmodule

bind iso_irq_link_regs iso_irq_link_regs_sva #(.CTX_COUNT(CTX_COUNT)) u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .soft_reset_i(soft_reset_i), .bus_req_i(bus_req_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
   .ctx_irq_i(ctx_irq_i), .main_event_low_i(main_event_low_i),
   .cycle_overrun_event_i(cycle_overrun_event_i),
   .rx_ctx_sync_filter_i(rx_ctx_sync_filter_i), .main_irq_o(main_irq_o),
   .rx_ctx_sync_filter_o(rx_ctx_sync_filter_o),
   .fairness_limit_o(fairness_limit_o), .link_flags_o(link_flags_o));
`default_nettype wire

// >>> sim/iso_irq_link_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module iso_irq_link_regs_bench;
   import iso_irq_link_pkg::*;
   // -------------------------------------------------------------------
   // Signals and counters
   // -------------------------------------------------------------------
   logic clk_i, rst_n_i, clk_en_i, soft_reset_i, cycle_overrun_event_i;
   bus_req_type bus_req_i;
   ctx_irq_type ctx_irq_i;
   logic [9:0] main_event_low_i;
   logic [7:0] rx_ctx_sync_filter_i, rx_ctx_sync_filter_o, fairness_limit_o;
   logic [31:0] readdata_o;
   logic waitrequest_o, main_irq_o;
   link_flags_type link_flags_o;
   int n_mismatch = 0;
   int checks_done = 0;

   iso_irq_link_regs #(.CTX_COUNT(8)) DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .soft_reset_i(soft_reset_i), .bus_req_i(bus_req_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .ctx_irq_i(ctx_irq_i), .main_event_low_i(main_event_low_i),
      .cycle_overrun_event_i(cycle_overrun_event_i),
      .rx_ctx_sync_filter_i(rx_ctx_sync_filter_i), .main_irq_o(main_irq_o),
      .rx_ctx_sync_filter_o(rx_ctx_sync_filter_o),
      .fairness_limit_o(fairness_limit_o), .link_flags_o(link_flags_o));

   // 40 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Avalon transfer; held until waitrequest is seen low at an edge.
   // An idle edge follows so the next call never re-drives in one step.
   task automatic bus_op(input logic [7:0] a, input logic rd,
                         input logic [31:0] d, input logic [3:0] be,
                         output logic [31:0] q);
      int n;
      n = 0;
      bus_req_i <= '{address: a, read: rd, write: !rd, writedata: d,
                     byteenable: be};
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      q = readdata_o;
      bus_req_i <= '0;
      if (n >= 100) begin
         chk("bus answer", 32'h0000_0001, 32'h0000_0000);
      end
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hf);
      logic [31:0] q;
      bus_op(a, 1'b0, d, be, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus_op(a, 1'b1, 32'h0000_0000, 4'hf, q);
      chk($sformatf("read %h", a), q, exp);
   endtask

   // Rising edge on the chosen context lines, then back low.
   task automatic pulse(input logic rx, input logic [7:0] bits);
      ctx_irq_i <= rx ? '{tx: 8'h00, rx: bits} : '{tx: bits, rx: 8'h00};
      repeat (2) @(posedge clk_i);
      ctx_irq_i <= '0;
      @(posedge clk_i);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_reset_values();
      logic [7:0] offs [0:12];
      offs = '{OFF_MAIN_MASK_SET, OFF_MAIN_MASK_CLEAR, OFF_MAIN_EVENT,
               OFF_TX_EVENT_SET, OFF_TX_EVENT_CLEAR, OFF_TX_MASK_SET,
               OFF_TX_MASK_CLEAR, OFF_RX_EVENT_SET, OFF_RX_EVENT_CLEAR,
               OFF_RX_MASK_SET, OFF_RX_MASK_CLEAR, OFF_FAIRNESS, 8'h40};
      foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
      rdc(OFF_LINK_CLEAR, 32'h0000_0000);
   endtask

   task automatic t_main_mask();
      wr(OFF_MAIN_MASK_SET, 32'hffff_ffff);
      rdc(OFF_MAIN_MASK_SET, 32'h0000_03ff);
      wr(OFF_MAIN_MASK_CLEAR, 32'h0000_0002);
      rdc(OFF_MAIN_MASK_CLEAR, 32'h0000_03fd);
      main_event_low_i <= 10'h002;
      repeat (2) @(posedge clk_i);
      chk("irq blocked", 32'(main_irq_o), 32'h0000_0000);
      // Bits 6 and 7 of the input must be hidden by the summaries.
      main_event_low_i <= 10'h2c1;
      wr(OFF_MAIN_EVENT, 32'hffff_ffff);
      chk("irq passed", 32'(main_irq_o), 32'h0000_0001);
      rdc(OFF_MAIN_EVENT, 32'h0000_0201);
      main_event_low_i <= 10'h000;
      wr(OFF_MAIN_MASK_CLEAR, 32'hffff_ffff);
      rdc(OFF_MAIN_MASK_SET, 32'h0000_0000);
   endtask

   // Serves both the transmit and receive banks through their offsets.
   task automatic t_ctx(input logic rx, input logic [7:0] es, ec, ms, mc,
                        input logic [31:0] sum);
      wr(OFF_MAIN_MASK_SET, 32'h0000_00c0);
      wr(ms, 32'hffff_ff0f);
      rdc(ms, 32'h0000_000f);
      rdc(mc, 32'h0000_000f);
      pulse(rx, 8'h81);
      rdc(es, 32'h0000_0081);
      rdc(ec, 32'h0000_0001);
      rdc(OFF_MAIN_EVENT, sum);
      chk("irq on", 32'(main_irq_o), 32'h0000_0001);
      wr(mc, 32'h0000_0001);
      rdc(es, 32'h0000_0081);
      chk("irq off", 32'(main_irq_o), 32'h0000_0000);
      wr(es, 32'hffff_ffff);
      rdc(es, 32'h0000_00ff);
      rdc(ec, 32'h0000_000e);
      wr(ec, 32'hffff_ffff);
      rdc(es, 32'h0000_0000);
      wr(mc, 32'hffff_ffff);
      wr(OFF_MAIN_MASK_CLEAR, 32'h0000_00c0);
      rdc(ms, 32'h0000_0000);
   endtask

   task automatic t_fairness();
      wr(OFF_FAIRNESS, 32'hffff_ffa5);
      rdc(OFF_FAIRNESS, 32'h0000_00a5);
      wr(OFF_FAIRNESS, 32'h0000_003c, 4'he);
      chk("limit", 32'(fairness_limit_o), 32'h0000_00a5);
      clk_en_i <= 1'b0;
      soft_reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("frozen", 32'(fairness_limit_o), 32'h0000_00a5);
      clk_en_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      @(posedge clk_i);
      rdc(OFF_FAIRNESS, 32'h0000_0000);
   endtask

   task automatic t_link();
      chk("filter", 32'(rx_ctx_sync_filter_o), 32'h0000_005a);
      wr(OFF_LINK_SET, 32'hffff_ffff);
      rdc(OFF_LINK_SET, 32'h0030_0640);
      rdc(OFF_LINK_CLEAR, 32'h0030_0640);
      chk("flags", 32'(link_flags_o), 32'h0000_001f);
      chk("filter", 32'(rx_ctx_sync_filter_o), 32'h0000_00ff);
      cycle_overrun_event_i <= 1'b1;
      wr(OFF_LINK_SET, 32'h0020_0000);
      rdc(OFF_LINK_SET, 32'h0010_0640);
      cycle_overrun_event_i <= 1'b0;
      wr(OFF_LINK_SET, 32'h0020_0000);
      rdc(OFF_LINK_SET, 32'h0030_0640);
      wr(OFF_LINK_CLEAR, 32'h0000_0600);
      rdc(OFF_LINK_SET, 32'h0030_0040);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      @(posedge clk_i);
      rdc(OFF_LINK_CLEAR, 32'h0000_0040);
      wr(OFF_LINK_CLEAR, 32'hffff_ffff);
      rdc(OFF_LINK_SET, 32'h0000_0000);
      chk("filter", 32'(rx_ctx_sync_filter_o), 32'h0000_005a);
   endtask

   // -------------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      clk_en_i = 1'b1;
      soft_reset_i = 1'b0;
      cycle_overrun_event_i = 1'b0;
      bus_req_i = '0;
      ctx_irq_i = '0;
      main_event_low_i = 10'h000;
      rx_ctx_sync_filter_i = 8'h5a;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset_values();
      t_main_mask();
      t_ctx(1'b0, OFF_TX_EVENT_SET, OFF_TX_EVENT_CLEAR, OFF_TX_MASK_SET,
            OFF_TX_MASK_CLEAR, 32'h0000_0040);
      t_ctx(1'b1, OFF_RX_EVENT_SET, OFF_RX_EVENT_CLEAR, OFF_RX_MASK_SET,
            OFF_RX_MASK_CLEAR, 32'h0000_0080);
      t_fairness();
      t_link();
      report_and_stop();
   end

   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
